// *** logic/mos_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the monitor scaler
`ifndef MOS_REGS_SVH
`define MOS_REGS_SVH

// Register byte offsets
`define MOS_ADDR_SRC 8'h00
`define MOS_ADDR_FREQ_REF 8'h04
`define MOS_ADDR_CUR_REF 8'h08
`define MOS_ADDR_FILT 8'h0C
`define MOS_ADDR_PCAL 8'h10
`define MOS_ADDR_ACAL 8'h14
`define MOS_ADDR_ACCESS 8'h18
`define MOS_ADDR_STATUS 8'h1C
`define MOS_ADDR_ANALOG 8'h20

// Field positions
`define MOS_SRC_PULSE_LSB 0
`define MOS_SRC_ANALOG_LSB 8
`define MOS_ACC_UGRP_LSB 8
`define MOS_STAT_PSAT_BIT 24
`define MOS_STAT_ASAT_BIT 25

// Reset values and write clamp limits
`define MOS_SRC_RST 5'h01
`define MOS_FREQ_REF_RST 16'h1770
`define MOS_FREQ_REF_MAX 32'h00009C40
`define MOS_CUR_REF_RST 20'h01388
`define MOS_CUR_REF_MAX 20'h0C350
`define MOS_FILT_RST 9'h001
`define MOS_FILT_MAX 32'h000001F4
`define MOS_CAL_RST 16'h1000

// Scaling: Q16 ratio, 1.0 = full scale
`define MOS_Q16_ONE 18'h10000
`define MOS_PULSE_FULL_PPS 1440
`define MOS_PULSE_MAX_PPS 2400
`define MOS_PULSE_CAP_Q16 ((`MOS_PULSE_MAX_PPS * 65536) / `MOS_PULSE_FULL_PPS)
`define MOS_DAC_FULL 16'hFFFF

// Timing
`define MOS_CLK_MHZ 50
`define MOS_FILT_TICK_US 1000
`define MOS_FILT_TICK_CYCLES (`MOS_FILT_TICK_US * `MOS_CLK_MHZ)
`define MOS_NCO_INC_FULL ((64'h1 * `MOS_PULSE_FULL_PPS * 64'h100000000) / (64'h1 * `MOS_CLK_MHZ * 1000000))
`define MOS_FILT_ZERO_MS 7
`define MOS_FILT_MIN_SHIFT 3
`define MOS_FILT_MAX_SHIFT 13

`endif

// *** logic/mos_pkg.sv ***
// Types shared by the monitor scaler
package mos_pkg;

  typedef enum logic [4:0] {
    MOS_SRC_NONE = 5'h00,
    MOS_SRC_FREQ = 5'h01,
    MOS_SRC_CURR = 5'h02,
    MOS_SRC_REF = 5'h15
  } mos_src_e;

  typedef enum logic [0:0] {
    MOS_DIV_IDLE = 1'b0,
    MOS_DIV_RUN = 1'b1
  } mos_div_e;

  typedef logic [17:0] mos_ratio_t;

endpackage

// *** logic/mos_pulse_gen.sv ***
// Phase-accumulator pulse train generator with a 50 percent duty square wave
`timescale 1ns/1ns
module mos_pulse_gen (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Phase increment per clock
  input wire logic [31:0] phaseInc,
  // Pulse train
  output logic pulseOut
);

  logic [31:0] phase;
  logic [31:0] next_phase;

  always_comb begin
    next_phase = phase + phaseInc;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 32'h00000000;
    end else begin
      phase <= next_phase;
    end
  end

  // Top bit toggles at exactly the programmed rate; no glitches since it is a flop
  assign pulseOut = phase[31];

endmodule

// *** logic/mos_lp_filter.sv ***
// First-order low-pass on the analog output code, stepped on a tick
`timescale 1ns/1ns
module mos_lp_filter (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic [3:0] shift,
  // Data
  input wire logic [15:0] target,
  output logic [15:0] filtered
);

  logic [31:0] acc;
  logic [31:0] next_acc;
  logic signed [32:0] diff;
  logic signed [32:0] step;

  always_comb begin
    diff = $signed({1'b0, target, 16'h0000}) - $signed({1'b0, acc});
    step = diff >>> shift;
    next_acc = acc;
    if (tick) begin
      // Fraction bits keep small steps from stalling at long time constants
      next_acc = acc + step[31:0];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= 32'h00000000;
    end else begin
      acc <= next_acc;
    end
  end

  assign filtered = acc[31:16];

endmodule

// *** logic/mos_monitor_output_scaler.sv ***
// Monitor output scaler: APB registers, ratio divider, pulse and analog monitor paths
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ns
`include "mos_regs.svh"

module mos_monitor_output_scaler #(
  parameter int unsigned FILT_TICK_CYCLES = `MOS_FILT_TICK_CYCLES,
  parameter logic [19:0] CUR_REF_RESET = `MOS_CUR_REF_RST,
  parameter logic [19:0] CUR_REF_MAX = `MOS_CUR_REF_MAX
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Monitored quantities, 0.01 Hz and 0.01 A units
  input wire logic [15:0] monFreq,
  input wire logic [19:0] monCurrent,
  input wire logic motorRunning,
  // Monitor outputs
  output logic pulseMonitorOut,
  output logic [15:0] analogMonitorOut
);

  // Configuration registers
  logic [4:0] pulseSourceSelect;
  logic [4:0] analogSourceSelect;
  logic [15:0] freqFullScaleRef;
  logic [19:0] currentFullScaleRef;
  logic [8:0] analogOutFilterTime;
  logic [15:0] pulseCalGain;
  logic [15:0] analogCalGain;
  logic [1:0] paramWriteSelect;
  logic [7:0] userGroupReadSelect;
  logic [4:0] next_pulseSourceSelect;
  logic [4:0] next_analogSourceSelect;
  logic [15:0] next_freqFullScaleRef;
  logic [19:0] next_currentFullScaleRef;
  logic [8:0] next_analogOutFilterTime;
  logic [15:0] next_pulseCalGain;
  logic [15:0] next_analogCalGain;
  logic [1:0] next_paramWriteSelect;
  logic [7:0] next_userGroupReadSelect;
  logic [31:0] next_prdata;

  // Scaled results
  mos_pkg::mos_ratio_t ratioPulse;
  mos_pkg::mos_ratio_t ratioAnalog;
  logic [17:0] pulseRate;
  logic pulseSat;
  logic [15:0] analogTarget;
  logic analogSat;

  logic accessPhase;
  logic addrMapped;
  logic addrReadOnly;
  logic generalOk;
  logic gainOk;
  logic writeBlocked;

  assign accessPhase = psel & penable;
  // No wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  // Mode 0 allows general writes only while stopped; mode 2 always; mode 1 never
  assign generalOk = ((paramWriteSelect == 2'h0) & ~motorRunning) | (paramWriteSelect == 2'h2);
  assign gainOk = (userGroupReadSelect == 8'h00);

  always_comb begin
    addrMapped = 1'b1;
    addrReadOnly = 1'b0;
    writeBlocked = 1'b0;
    unique case (paddr)
      `MOS_ADDR_SRC, `MOS_ADDR_FILT: writeBlocked = ~generalOk;
      `MOS_ADDR_FREQ_REF, `MOS_ADDR_CUR_REF, `MOS_ADDR_ACCESS: writeBlocked = 1'b0;
      `MOS_ADDR_PCAL, `MOS_ADDR_ACAL: writeBlocked = ~gainOk;
      `MOS_ADDR_STATUS, `MOS_ADDR_ANALOG: addrReadOnly = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  end

  assign pslverr = accessPhase & (~addrMapped | (pwrite & (addrReadOnly | writeBlocked)));

  always_comb begin
    next_pulseSourceSelect = pulseSourceSelect;
    next_analogSourceSelect = analogSourceSelect;
    next_freqFullScaleRef = freqFullScaleRef;
    next_currentFullScaleRef = currentFullScaleRef;
    next_analogOutFilterTime = analogOutFilterTime;
    next_pulseCalGain = pulseCalGain;
    next_analogCalGain = analogCalGain;
    next_paramWriteSelect = paramWriteSelect;
    next_userGroupReadSelect = userGroupReadSelect;
    next_prdata = prdata;
    if (accessPhase & pwrite & addrMapped & ~addrReadOnly & ~writeBlocked) begin
      unique case (paddr)
        `MOS_ADDR_SRC: begin
          next_pulseSourceSelect = pwdata[`MOS_SRC_PULSE_LSB +: 5];
          next_analogSourceSelect = pwdata[`MOS_SRC_ANALOG_LSB +: 5];
        end
        `MOS_ADDR_FREQ_REF: begin
          // Out-of-range settings clamp to 400.00 Hz
          next_freqFullScaleRef = (pwdata > `MOS_FREQ_REF_MAX) ?
              16'(`MOS_FREQ_REF_MAX) : pwdata[15:0];
        end
        `MOS_ADDR_CUR_REF: begin
          next_currentFullScaleRef = (pwdata > {12'h000, CUR_REF_MAX}) ?
              CUR_REF_MAX : pwdata[19:0];
        end
        `MOS_ADDR_FILT: begin
          next_analogOutFilterTime = (pwdata > `MOS_FILT_MAX) ?
              9'(`MOS_FILT_MAX) : pwdata[8:0];
        end
        `MOS_ADDR_PCAL: next_pulseCalGain = pwdata[15:0];
        `MOS_ADDR_ACAL: next_analogCalGain = pwdata[15:0];
        `MOS_ADDR_ACCESS: begin
          next_paramWriteSelect = pwdata[1:0];
          next_userGroupReadSelect = pwdata[`MOS_ACC_UGRP_LSB +: 8];
        end
        default: next_prdata = prdata;
      endcase
    end
    if (psel & ~penable & ~pwrite) begin
      next_prdata = 32'h00000000;
      unique case (paddr)
        `MOS_ADDR_SRC: begin
          next_prdata[`MOS_SRC_PULSE_LSB +: 5] = pulseSourceSelect;
          next_prdata[`MOS_SRC_ANALOG_LSB +: 5] = analogSourceSelect;
        end
        `MOS_ADDR_FREQ_REF: next_prdata[15:0] = freqFullScaleRef;
        `MOS_ADDR_CUR_REF: next_prdata[19:0] = currentFullScaleRef;
        `MOS_ADDR_FILT: next_prdata[8:0] = analogOutFilterTime;
        `MOS_ADDR_PCAL: next_prdata[15:0] = pulseCalGain;
        `MOS_ADDR_ACAL: next_prdata[15:0] = analogCalGain;
        `MOS_ADDR_ACCESS: begin
          next_prdata[1:0] = paramWriteSelect;
          next_prdata[`MOS_ACC_UGRP_LSB +: 8] = userGroupReadSelect;
        end
        `MOS_ADDR_STATUS: begin
          next_prdata[17:0] = pulseRate;
          next_prdata[`MOS_STAT_PSAT_BIT] = pulseSat;
          next_prdata[`MOS_STAT_ASAT_BIT] = analogSat;
        end
        `MOS_ADDR_ANALOG: next_prdata[15:0] = analogMonitorOut;
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseSourceSelect <= `MOS_SRC_RST;
      analogSourceSelect <= `MOS_SRC_RST;
      freqFullScaleRef <= `MOS_FREQ_REF_RST;
      currentFullScaleRef <= CUR_REF_RESET;
      analogOutFilterTime <= `MOS_FILT_RST;
      pulseCalGain <= `MOS_CAL_RST;
      analogCalGain <= `MOS_CAL_RST;
      paramWriteSelect <= 2'h0;
      userGroupReadSelect <= 8'h00;
      prdata <= 32'h00000000;
    end else begin
      pulseSourceSelect <= next_pulseSourceSelect;
      analogSourceSelect <= next_analogSourceSelect;
      freqFullScaleRef <= next_freqFullScaleRef;
      currentFullScaleRef <= next_currentFullScaleRef;
      analogOutFilterTime <= next_analogOutFilterTime;
      pulseCalGain <= next_pulseCalGain;
      analogCalGain <= next_analogCalGain;
      paramWriteSelect <= next_paramWriteSelect;
      userGroupReadSelect <= next_userGroupReadSelect;
      prdata <= next_prdata;
    end
  end

  // Serial divider, value * 2^16 / reference, alternating between the two outputs
  mos_pkg::mos_div_e divState;
  mos_pkg::mos_div_e next_divState;
  logic divSel;
  logic next_divSel;
  logic [5:0] divCnt;
  logic [5:0] next_divCnt;
  logic [35:0] divNum;
  logic [35:0] next_divNum;
  logic [19:0] divDen;
  logic [19:0] next_divDen;
  logic [20:0] divRem;
  logic [20:0] next_divRem;
  logic [35:0] divQuo;
  logic [35:0] next_divQuo;
  mos_pkg::mos_ratio_t next_ratioPulse;
  mos_pkg::mos_ratio_t next_ratioAnalog;
  logic [4:0] selSrc;
  logic [19:0] selValue;
  logic [19:0] selDen;
  logic [20:0] trial;
  logic trialGe;
  logic [35:0] finalQuo;
  mos_pkg::mos_ratio_t satQuo;

  always_comb begin
    next_divState = divState;
    next_divSel = divSel;
    next_divCnt = divCnt;
    next_divNum = divNum;
    next_divDen = divDen;
    next_divRem = divRem;
    next_divQuo = divQuo;
    next_ratioPulse = ratioPulse;
    next_ratioAnalog = ratioAnalog;
    selSrc = divSel ? analogSourceSelect : pulseSourceSelect;
    selValue = 20'h00000;
    selDen = 20'h00000;
    if (selSrc == 5'(mos_pkg::MOS_SRC_FREQ)) begin
      selValue = {4'h0, monFreq};
      selDen = {4'h0, freqFullScaleRef};
    end else if (selSrc == 5'(mos_pkg::MOS_SRC_CURR)) begin
      selValue = monCurrent;
      selDen = currentFullScaleRef;
    end
    trial = {divRem[19:0], divNum[35]};
    trialGe = (trial >= {1'b0, divDen});
    finalQuo = {divQuo[34:0], trialGe};
    // Ratios beyond 4x full scale saturate; outputs cap far below that anyway
    satQuo = (|finalQuo[35:18]) ? 18'h3FFFF : finalQuo[17:0];
    unique case (divState)
      mos_pkg::MOS_DIV_IDLE: begin
        if (selDen == 20'h00000) begin
          // Unselected source or zero reference reads as zero
          if (divSel) next_ratioAnalog = 18'h00000;
          else next_ratioPulse = 18'h00000;
          next_divSel = ~divSel;
        end else begin
          next_divNum = {selValue, 16'h0000};
          next_divDen = selDen;
          next_divRem = 21'h000000;
          next_divQuo = 36'h000000000;
          next_divCnt = 6'h00;
          next_divState = mos_pkg::MOS_DIV_RUN;
        end
      end
      mos_pkg::MOS_DIV_RUN: begin
        next_divRem = trialGe ? (trial - {1'b0, divDen}) : trial;
        next_divQuo = finalQuo;
        next_divNum = {divNum[34:0], 1'b0};
        next_divCnt = divCnt + 6'h01;
        if (divCnt == 6'h23) begin
          if (divSel) next_ratioAnalog = satQuo;
          else next_ratioPulse = satQuo;
          next_divSel = ~divSel;
          next_divState = mos_pkg::MOS_DIV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      divState <= mos_pkg::MOS_DIV_IDLE;
      divSel <= 1'b0;
      divCnt <= 6'h00;
      divNum <= 36'h000000000;
      divDen <= 20'h00000;
      divRem <= 21'h000000;
      divQuo <= 36'h000000000;
      ratioPulse <= 18'h00000;
      ratioAnalog <= 18'h00000;
    end else begin
      divState <= next_divState;
      divSel <= next_divSel;
      divCnt <= next_divCnt;
      divNum <= next_divNum;
      divDen <= next_divDen;
      divRem <= next_divRem;
      divQuo <= next_divQuo;
      ratioPulse <= next_ratioPulse;
      ratioAnalog <= next_ratioAnalog;
    end
  end

  // Gain, reference output and saturation
  logic [33:0] pulseProd;
  logic [33:0] analogProd;
  logic [17:0] next_pulseRate;
  logic next_pulseSat;
  logic [15:0] next_analogTarget;
  logic next_analogSat;

  always_comb begin
    pulseProd = 34'(ratioPulse) * 34'(pulseCalGain);
    analogProd = 34'(ratioAnalog) * 34'(analogCalGain);
    next_pulseSat = 1'b0;
    next_analogSat = 1'b0;
    if (pulseSourceSelect == 5'(mos_pkg::MOS_SRC_REF)) begin
      next_pulseRate = `MOS_Q16_ONE;
    end else if (pulseProd[33:12] > 22'(`MOS_PULSE_CAP_Q16)) begin
      next_pulseRate = 18'(`MOS_PULSE_CAP_Q16);
      next_pulseSat = 1'b1;
    end else begin
      next_pulseRate = pulseProd[29:12];
    end
    if (analogSourceSelect == 5'(mos_pkg::MOS_SRC_REF)) begin
      next_analogTarget = `MOS_DAC_FULL;
    end else if (|analogProd[33:28]) begin
      next_analogTarget = `MOS_DAC_FULL;
      next_analogSat = 1'b1;
    end else begin
      next_analogTarget = analogProd[27:12];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseRate <= 18'h00000;
      pulseSat <= 1'b0;
      analogTarget <= 16'h0000;
      analogSat <= 1'b0;
    end else begin
      pulseRate <= next_pulseRate;
      pulseSat <= next_pulseSat;
      analogTarget <= next_analogTarget;
      analogSat <= next_analogSat;
    end
  end

  // Pulse path: rate in Q16 of 1440/s to a phase increment
  logic [63:0] ncoProd;
  logic [31:0] phaseInc;
  assign ncoProd = 64'(pulseRate) * `MOS_NCO_INC_FULL;
  assign phaseInc = ncoProd[47:16];

  mos_pulse_gen mos_pulse_gen_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .phaseInc(phaseInc),
    .pulseOut(pulseMonitorOut)
  );

  // Filter tick divider, 1 ms step
  logic [31:0] tickCnt;
  logic [31:0] next_tickCnt;
  logic filtTick;
  logic next_filtTick;

  always_comb begin
    next_filtTick = (tickCnt == 32'(FILT_TICK_CYCLES - 1));
    next_tickCnt = next_filtTick ? 32'h00000000 : tickCnt + 32'h00000001;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt <= 32'h00000000;
      filtTick <= 1'b0;
    end else begin
      tickCnt <= next_tickCnt;
      filtTick <= next_filtTick;
    end
  end

  // Time constant rounded up to a power of two milliseconds; a coarse but cheap fit
  function automatic logic [3:0] filtShift(input logic [8:0] setting);
    logic [13:0] tauMs;
    logic [3:0] k;
    tauMs = 14'(setting) * 14'h000A;
    k = 4'(`MOS_FILT_MAX_SHIFT);
    for (int i = `MOS_FILT_MAX_SHIFT; i >= `MOS_FILT_MIN_SHIFT; i--) begin
      if ((32'h00000001 << i) >= 32'(tauMs)) k = 4'(i);
    end
    return k;
  endfunction

  logic [3:0] lpShift;
  assign lpShift = filtShift(analogOutFilterTime);

  mos_lp_filter mos_lp_filter_inst (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tick(filtTick),
    .shift(lpShift),
    .target(analogTarget),
    .filtered(analogMonitorOut)
  );

endmodule

// *** verif/mos_scaler_asserts.sv ***
// Concurrent checks on the monitor scaler ports, bound to the top module
`timescale 1ns/1ns
module mos_scaler_asserts (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Monitor side
  input wire logic [15:0] monFreq,
  input wire logic [19:0] monCurrent,
  input wire logic motorRunning,
  input wire logic pulseMonitorOut,
  input wire logic [15:0] analogMonitorOut
);
  logic wrAcc;
  logic rdAcc;
  logic [1:0] pws;
  logic [1:0] next_pws;
  logic [7:0] ugrp;
  logic [7:0] next_ugrp;
  logic [31:0] hiCnt;
  logic [31:0] next_hiCnt;
  logic [31:0] loCnt;
  logic [31:0] next_loCnt;
  assign wrAcc = psel && penable && pwrite;
  assign rdAcc = psel && penable && !pwrite;
  // Mirror of the access register; it is always writable, so no refusal to track
  always_comb begin
    next_pws = pws;
    next_ugrp = ugrp;
    if (wrAcc && paddr == 8'h18) begin
      next_pws = pwdata[1:0];
      next_ugrp = pwdata[15:8];
    end
    next_hiCnt = pulseMonitorOut ? hiCnt + 32'h1 : 32'h0;
    next_loCnt = pulseMonitorOut ? 32'h0 : loCnt + 32'h1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pws <= 2'h0;
      ugrp <= 8'h0;
      hiCnt <= 32'h0;
      loCnt <= 32'h0;
    end else begin
      pws <= next_pws;
      ugrp <= next_ugrp;
      hiCnt <= next_hiCnt;
      loCnt <= next_loCnt;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  chk_ref_wr_ok:
  assert property (wrAcc && paddr inside {8'h04, 8'h08} |-> !pslverr)
    else $error("reference write refused");
  chk_src_gate:
  assert property (wrAcc && paddr inside {8'h00, 8'h0C} |->
    pslverr == !(pws == 2'h2 || (pws == 2'h0 && !motorRunning)))
    else $error("source write gate wrong");
  chk_gain_gated:
  assert property (wrAcc && paddr inside {8'h10, 8'h14} |-> pslverr == (ugrp != 8'h0))
    else $error("gain write gate wrong");
  chk_freq_clamp:
  assert property (rdAcc && paddr == 8'h04 |-> prdata <= 32'h9C40)
    else $error("frequency reference above range");
  chk_filt_clamp:
  assert property (rdAcc && paddr == 8'h0C |-> prdata <= 32'h1F4)
    else $error("filter time above range");
  chk_rate_cap:
  assert property (rdAcc && paddr == 8'h1C |-> prdata[17:0] <= 18'h1AAAA)
    else $error("pulse rate above cap");
  chk_cap_flag:
  assert property (rdAcc && paddr == 8'h1C && prdata[24] |-> prdata[17:0] == 18'h1AAAA)
    else $error("cap flag without capped rate");
  chk_pulse_high:
  assert property ($fell(pulseMonitorOut) |-> hiCnt >= 32'h28AF)
    else $error("pulse high phase too short");
  chk_pulse_low:
  assert property ($rose(pulseMonitorOut) |-> loCnt >= 32'h28AF)
    else $error("pulse low phase too short");
  chk_analog_read:
  assert property (rdAcc && paddr == 8'h20 |-> prdata[15:0] == $past(analogMonitorOut))
    else $error("analog readback differs from output");
endmodule

bind mos_monitor_output_scaler mos_scaler_asserts mos_scaler_asserts_inst (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .monFreq(monFreq), .monCurrent(monCurrent), .motorRunning(motorRunning),
  .pulseMonitorOut(pulseMonitorOut), .analogMonitorOut(analogMonitorOut)
);

// *** verif/mos_meter_model.sv ***
// Behavioural pulse counter that measures the period of the pulse monitor output
`timescale 1ns/1ns
module mos_meter_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Pulse input and readings
  input wire logic pulseIn,
  output logic [31:0] period,
  output logic [15:0] riseCount
);
  logic prevIn;
  logic [31:0] sinceRise;
  // Period is counted rise to rise, so duty cycle never enters the reading
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevIn <= 1'b0;
      sinceRise <= 32'h0;
      period <= 32'h0;
      riseCount <= 16'h0;
    end else begin
      prevIn <= pulseIn;
      sinceRise <= sinceRise + 32'h1;
      if (pulseIn && !prevIn) begin
        period <= sinceRise;
        sinceRise <= 32'h1;
        riseCount <= riseCount + 16'h1;
      end
    end
  end
endmodule

// *** verif/mos_monitor_output_scaler_tb.sv ***
// Self-checking bench for the monitor scaler: APB tasks and monitor scenarios
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmpCount++; if ((g) !== (e)) begin errors++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module mos_monitor_output_scaler_tb;
  logic core_clk;
  logic rst_n;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] monFreq;
  logic [19:0] monCurrent;
  logic motorRunning;
  logic pulseMonitorOut;
  logic [15:0] analogMonitorOut;
  logic [31:0] period;
  logic [15:0] riseCount;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmpCount = 0;
  logic [7:0] defAddr [7] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18};
  logic [31:0] defVal [7] = '{32'h101, 32'h1770, 32'h1388, 32'h1, 32'h1000, 32'h1000, 32'h0};

  // Short filter tick keeps analog settling within a few thousand cycles
  mos_monitor_output_scaler #(.FILT_TICK_CYCLES(50)) mos_monitor_output_scaler_inst (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .monFreq(monFreq), .monCurrent(monCurrent), .motorRunning(motorRunning),
    .pulseMonitorOut(pulseMonitorOut), .analogMonitorOut(analogMonitorOut)
  );
  mos_meter_model mos_meter_model_inst (
    .core_clk(core_clk), .rst_n(rst_n), .pulseIn(pulseMonitorOut),
    .period(period), .riseCount(riseCount)
  );

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    if (errors == 0 && cmpCount > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      give_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wrChk(input logic [7:0] a, input logic [31:0] d, input logic e);
    apb(1'b1, a, d);
    `CHK("write error", e, err)
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK("read data", e, rd & m)
  endtask

  task automatic settle();
    repeat (4000) @(posedge core_clk);
  endtask

  task automatic analogNear(input logic [15:0] lo, input logic [15:0] hi);
    `CHK("analog level", 1'b1, (analogMonitorOut >= lo) && (analogMonitorOut <= hi))
  endtask

  task automatic waitRises();
    logic [15:0] start;
    int n = 0;
    start = riseCount;
    while (16'(riseCount - start) < 16'h2 && n < 60000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 60000) begin
      errors++;
      give_verdict();
    end
  endtask

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    monFreq = 16'h0;
    monCurrent = 20'h0;
    motorRunning = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rdChk(defAddr[i], 32'hFFFFFFFF, defVal[i]);
    end
    rdChk(8'h24, 32'hFFFFFFFF, 32'h0);
    `CHK("unmapped error", 1'b1, err)
    wrChk(8'h1C, 32'h0, 1'b1);
    wrChk(8'h04, 32'hC350, 1'b0);
    rdChk(8'h04, 32'hFFFFFFFF, 32'h9C40);
    wrChk(8'h0C, 32'h258, 1'b0);
    rdChk(8'h0C, 32'hFFFFFFFF, 32'h1F4);
    wrChk(8'h0C, 32'h0, 1'b0);
    wrChk(8'h04, 32'h1770, 1'b0);
    motorRunning <= 1'b1;
    wrChk(8'h00, 32'h101, 1'b1);
    wrChk(8'h04, 32'h1770, 1'b0);
    wrChk(8'h10, 32'h1000, 1'b0);
    wrChk(8'h18, 32'h2, 1'b0);
    wrChk(8'h0C, 32'h0, 1'b0);
    wrChk(8'h18, 32'h1, 1'b0);
    motorRunning <= 1'b0;
    wrChk(8'h0C, 32'h1F4, 1'b1);
    rdChk(8'h0C, 32'hFFFFFFFF, 32'h0);
    wrChk(8'h04, 32'h1770, 1'b0);
    wrChk(8'h18, 32'h100, 1'b0);
    wrChk(8'h10, 32'h1000, 1'b1);
    wrChk(8'h14, 32'h1000, 1'b1);
    wrChk(8'h18, 32'h0, 1'b0);
    wrChk(8'h14, 32'h1000, 1'b0);
    monFreq <= 16'h1770;
    settle();
    rdChk(8'h1C, 32'h0103FFFF, 32'h10000);
    analogNear(16'hFFF0, 16'hFFFF);
    wrChk(8'h14, 32'h800, 1'b0);
    settle();
    analogNear(16'h7FF0, 16'h8010);
    wrChk(8'h14, 32'h2000, 1'b0);
    monFreq <= 16'hBB8;
    settle();
    rdChk(8'h1C, 32'h0203FFFF, 32'h02008000);
    analogNear(16'hFFF0, 16'hFFFF);
    monFreq <= 16'h2EE0;
    settle();
    rdChk(8'h1C, 32'h0103FFFF, 32'h0101AAAA);
    waitRises();
    `CHK("pulse period", 1'b1, period > 32'h515C && period < 32'h5167)
    wrChk(8'h14, 32'h1000, 1'b0);
    wrChk(8'h00, 32'h202, 1'b0);
    monCurrent <= 20'h9C4;
    settle();
    rdChk(8'h1C, 32'h0003FFFF, 32'h8000);
    analogNear(16'h7FF0, 16'h8010);
    wrChk(8'h10, 32'h2000, 1'b0);
    wrChk(8'h00, 32'h1515, 1'b0);
    monCurrent <= 20'h0;
    monFreq <= 16'h0;
    settle();
    rdChk(8'h1C, 32'h0103FFFF, 32'h10000);
    analogNear(16'hFFF0, 16'hFFFF);
    apb(1'b0, 8'h20, 32'h0);
    give_verdict();
  end
endmodule
